//--- rtl/fmh_pkg.sv
// shared constants, types and helpers for the flash link and its controller
package fmh_pkg;
  localparam int CLK_MHZ = 25;
  localparam int NS_PER_US = 1000;
  // times in ns; cycle counts derived from the clock rate
  localparam int RST_PIN_NS = 1000;
  localparam int SW_RST_NS = 10000;
  localparam int EMB_OP_NS = 2000;
  localparam int TW = 12;
  // least time rounds up
  localparam logic [TW-1:0] RST_PIN_CYC = TW'((RST_PIN_NS * CLK_MHZ + NS_PER_US - 1) / NS_PER_US);
  // approximate time rounds down
  localparam logic [TW-1:0] SW_RST_CYC = TW'(SW_RST_NS * CLK_MHZ / NS_PER_US);
  localparam logic [TW-1:0] EMB_OP_CYC = TW'((EMB_OP_NS * CLK_MHZ + NS_PER_US - 1) / NS_PER_US);
  // command opcodes
  localparam logic [7:0] OP_WREN = 8'h06;
  localparam logic [7:0] OP_WRDI = 8'h04;
  localparam logic [7:0] OP_VWREN = 8'h50;
  localparam logic [7:0] OP_WR_SR1 = 8'h01;
  localparam logic [7:0] OP_WR_SR2 = 8'h31;
  localparam logic [7:0] OP_WR_SR3 = 8'h11;
  localparam logic [7:0] OP_RD_SR1 = 8'h05;
  localparam logic [7:0] OP_RD_SR2 = 8'h35;
  localparam logic [7:0] OP_RD_SR3 = 8'h15;
  localparam logic [7:0] OP_RST_EN = 8'h66;
  localparam logic [7:0] OP_RST = 8'h99;
  localparam logic [7:0] OP_RD_DUAL_OUT = 8'h3b;
  localparam logic [7:0] OP_RD_DUAL_IO = 8'hbb;
  localparam logic [7:0] OP_RD_QUAD_OUT = 8'h6b;
  localparam logic [7:0] OP_RD_QUAD_IO = 8'heb;
  localparam logic [7:0] OP_RD_QUAD_WORD = 8'he7;
  localparam logic [7:0] OP_PROG = 8'h02;
  localparam logic [7:0] OP_ERASE = 8'h20;
  // dummy clocks after the address
  localparam logic [3:0] DUM_OUT = 4'h8;
  localparam logic [3:0] DUM_DUAL_IO = 4'h4;
  localparam logic [3:0] DUM_QUAD_IO = 4'h6;
  localparam logic [3:0] DUM_QUAD_WORD = 4'h4;
  localparam logic [4:0] ADDR_BITS = 5'h18;
  localparam logic [3:0] BYTE_BITS = 4'h8;
  localparam logic [7:0] ERASED = 8'hff;
  // status register fields
  localparam int SR1_LOCK0 = 7;
  localparam int SR1_WEL = 1;
  localparam int SR1_BUSY = 0;
  localparam int SR2_LOCK1 = 0;
  localparam int SR2_QE = 1;
  localparam int SR3_PFS = 7;
  localparam logic [7:0] SR1_WMASK = 8'hfc;
  localparam logic [7:0] SR2_WMASK = 8'h7b;
  localparam logic [7:0] SR3_WMASK = 8'hf0;
  // sampled link vector {cs_n, sclk, io[3:0]}
  localparam logic [5:0] LK_RST = 6'h2f;
  localparam int LK_CS = 5;
  localparam int LK_SCLK = 4;
  localparam int LK_PIN3 = 3;
  localparam int LK_GUARD = 2;
  // controller registers
  localparam int APB_AW = 12;
  localparam logic [APB_AW-1:0] A_XFER = 12'h000;
  localparam logic [APB_AW-1:0] A_STAT = 12'h004;
  localparam logic [APB_AW-1:0] A_PINS = 12'h008;
  localparam logic [APB_AW-1:0] A_DIV = 12'h00c;
  localparam int XF_W = 12;
  localparam int XF_LANE = 8;
  localparam int XF_RD = 10;
  localparam int XF_END = 11;
  localparam int PN_GUARD = 0;
  localparam int PN_PIN3 = 1;
  localparam logic [1:0] PINS_RST = 2'h3;
  localparam logic [7:0] DIV_RST = 8'h04;
  localparam logic [7:0] DIV_MIN = 8'h04;

  typedef enum logic [1:0] {LN_ONE, LN_TWO, LN_FOUR} fmh_lanes_t;

  typedef struct packed {
    logic has_addr;
    fmh_lanes_t alanes;
    logic [3:0] dummy;
    fmh_lanes_t dlanes;
    logic rd;
    logic quad;
  } fmh_cmd_t;

  // bits moved per clock for a lane mode
  function automatic logic [3:0] lane_w(input fmh_lanes_t l);
    lane_w = 4'h1 << l;
  endfunction : lane_w

  function automatic logic [7:0] merge(input logic [7:0] old, input logic [7:0] nw, input logic [7:0] m);
    merge = (old & ~m) | (nw & m);
  endfunction : merge
endpackage : fmh_pkg

//--- rtl/fmh_spi_if.sv
// serial link between the flash end and the controller end
interface fmh_spi_if;
  logic sclk;
  logic cs_n;
  logic [3:0] h_o;
  logic [3:0] h_oe_n;
  logic [3:0] d_o;
  logic [3:0] d_oe_n;
  logic [3:0] io;
  // wire level: device driver, then host driver, else pull-up
  assign io = (~d_oe_n & d_o) | (d_oe_n & ~h_oe_n & h_o) | (d_oe_n & h_oe_n);
  modport dev (input sclk, input cs_n, input io, output d_o, output d_oe_n);
  modport host (output sclk, output cs_n, output h_o, output h_oe_n, input io);
endinterface : fmh_spi_if

//--- rtl/fmh_dev.sv
// flash end: serial command decode, pause, resets and status registers
////////////////////////////////////////////////////////////////////////////////
// Summary of operation
// - dual reads use two bidirectional data lines
// - quad reads use all four data lines
// - quad commands need four-line enable set
// - pause only outside quad operations
// - host keeps select low while pausing
// - pause enters on pin fall, clock low
// - pause exits on pin rise, clock low
// - paused: outputs float, clock and data ignored
// - deselect during pause resets interface state
// - software reset needs enable then reset
// - software reset period rejects all commands
// - pin select chooses pause or reset pin
// - reset pin low blocks commands, resets
// - four-line enable disables pause and reset
// - suspend, permit, busy are internal read-only
// - permit latch set by enable, cleared after
// - stored status write needs lock, enable, guard
// - resets reload volatile copies; volatile write path
// - volatile one/two writes need volatile enable
// - volatile three write needs only volatile enable
// - first status register layout, resets zero
// - embedded operations need permit, report busy
// - sample on rising, present on falling clock
// - busy: only first status read accepted
//
// Our own choices: the APB register port and the placing of the registers.
module fmh_dev
  import fmh_pkg::*;
(
  input wire logic ref_clk,
  input wire logic resetn,
  fmh_spi_if.dev spi,
  output logic [7:0] status_one_protection,
  output logic four_line_enable,
  output logic pin_function_select,
  output logic reset_active
);
  typedef enum logic [2:0] {PH_CMD, PH_ADDR, PH_DUMMY, PH_OUT, PH_IN, PH_IGN} fmh_ph_t;

  // command table: lanes, dummy clocks, direction
  function automatic fmh_cmd_t decode(input logic [7:0] op);
    fmh_cmd_t c;
    c = '0;
    case (op)
      OP_RD_DUAL_OUT: begin
        c.has_addr = 1'b1; c.dummy = DUM_OUT; c.dlanes = LN_TWO; c.rd = 1'b1;
      end
      OP_RD_DUAL_IO: begin
        c.has_addr = 1'b1; c.alanes = LN_TWO; c.dummy = DUM_DUAL_IO; c.dlanes = LN_TWO; c.rd = 1'b1;
      end
      OP_RD_QUAD_OUT: begin
        c.has_addr = 1'b1; c.dummy = DUM_OUT; c.dlanes = LN_FOUR; c.rd = 1'b1; c.quad = 1'b1;
      end
      OP_RD_QUAD_IO: begin
        c.has_addr = 1'b1; c.alanes = LN_FOUR; c.dummy = DUM_QUAD_IO; c.dlanes = LN_FOUR; c.rd = 1'b1;
        c.quad = 1'b1;
      end
      OP_RD_QUAD_WORD: begin
        c.has_addr = 1'b1; c.alanes = LN_FOUR; c.dummy = DUM_QUAD_WORD; c.dlanes = LN_FOUR; c.rd = 1'b1;
        c.quad = 1'b1;
      end
      OP_PROG, OP_ERASE: c.has_addr = 1'b1;
      OP_RD_SR1, OP_RD_SR2, OP_RD_SR3: c.rd = 1'b1;
      default: c = '0;
    endcase
    decode = c;
  endfunction : decode

  function automatic logic is_wrsr(input logic [7:0] op);
    is_wrsr = (op == OP_WR_SR1) || (op == OP_WR_SR2) || (op == OP_WR_SR3);
  endfunction : is_wrsr

  logic [5:0] ln1_q, ln2_q, ln3_q;
  fmh_ph_t ph_q, ph_d;
  fmh_cmd_t cmd_q, cmd_d;
  logic [4:0] cnt_q, cnt_d;
  logic [7:0] op_q, op_d, sh_q, sh_d, wb0_q, wb0_d, wb1_q, wb1_d, osh_q, osh_d;
  logic [7:0] sr1_q, sr1_d, sr2_q, sr2_d, sr3_q, sr3_d, nv1_q, nv1_d, nv2_q, nv2_d, nv3_q, nv3_d;
  logic [1:0] nb_q, nb_d;
  logic [3:0] oleft_q, oleft_d, io_o_q, io_o_d, drv_q, drv_d, oe_n_q, oe_n_d;
  logic hold_q, hold_d, arm_q, arm_d, vwe_q, vwe_d, rst_act_q, rst_act_d;
  logic [TW-1:0] opc_q, opc_d, srt_q, srt_d, rpc_q, rpc_d;
  logic cs_n, sclk, rise, fall, qe, hold_en, pin_low, lock_ok, init, wr_ok, wr2;
  logic [7:0] b, by;
  logic [3:0] w;
  fmh_cmd_t c;

  ////////////////////////////////////////////////////////////////////////////////
  // link inputs come from the host's domain: two flops, third only for edges
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      ln1_q <= LK_RST;
      ln2_q <= LK_RST;
      ln3_q <= LK_RST;
    end else begin
      ln1_q <= {spi.cs_n, spi.sclk, spi.io};
      ln2_q <= ln1_q;
      ln3_q <= ln2_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // command engine, pause, resets and status
  always_comb begin
    ph_d = ph_q; cmd_d = cmd_q; cnt_d = cnt_q; op_d = op_q; sh_d = sh_q;
    wb0_d = wb0_q; wb1_d = wb1_q; osh_d = osh_q; nb_d = nb_q; oleft_d = oleft_q;
    sr1_d = sr1_q; sr2_d = sr2_q; sr3_d = sr3_q; nv1_d = nv1_q; nv2_d = nv2_q; nv3_d = nv3_q;
    io_o_d = io_o_q; drv_d = drv_q; hold_d = hold_q; arm_d = arm_q; vwe_d = vwe_q;
    opc_d = opc_q; srt_d = srt_q; rpc_d = rpc_q;
    init = 1'b0;
    wr2 = 1'b0;
    wr_ok = 1'b0;
    c = '0;
    w = lane_w(LN_ONE);
    by = osh_q;
    cs_n = ln2_q[LK_CS];
    sclk = ln2_q[LK_SCLK];
    rise = sclk & ~ln3_q[LK_SCLK];
    fall = ~sclk & ln3_q[LK_SCLK];
    b = {sh_q[6:0], ln2_q[0]};
    qe = sr2_q[SR2_QE];
    hold_en = ~qe & ~sr3_q[SR3_PFS];
    pin_low = ~qe & sr3_q[SR3_PFS] & ~ln2_q[LK_PIN3];
    // guard pin matters only outside quad mode
    lock_ok = ~nv2_q[SR2_LOCK1] & ~(nv1_q[SR1_LOCK0] & ~ln2_q[LK_GUARD] & ~qe);
    // embedded operation timer; permit latch drops at completion
    if (opc_q != '0) begin
      opc_d = opc_q - 1'b1;
      if (opc_q == TW'(1)) begin
        sr1_d[SR1_BUSY] = 1'b0;
        sr1_d[SR1_WEL] = 1'b0;
      end
    end
    if (srt_q != '0) srt_d = srt_q - 1'b1;
    // reset pin: count low cycles, fire once at the least width
    if (pin_low) begin
      if (rpc_q != RST_PIN_CYC) rpc_d = rpc_q + 1'b1;
      if (rpc_q == RST_PIN_CYC - 1'b1) init = 1'b1;
    end else begin
      rpc_d = '0;
    end
    if (cs_n | pin_low) begin
      // deselect or reset pin low drops the frame, pause included
      ph_d = PH_CMD; cnt_d = '0; nb_d = '0; oleft_d = '0; drv_d = '0; cmd_d = '0;
      hold_d = 1'b0;
      if (cs_n && ph_q == PH_IN && nb_q != '0) begin
        wr2 = (op_q == OP_WR_SR2) || (op_q == OP_WR_SR1 && nb_q == 2'h2);
        wr_ok = vwe_q ? (op_q == OP_WR_SR3 || lock_ok)
                      : (sr1_q[SR1_WEL] && (op_q == OP_WR_SR3 || lock_ok));
        if (wr_ok) begin
          if (op_q == OP_WR_SR1) sr1_d = merge(sr1_q, wb0_q, SR1_WMASK);
          if (wr2) sr2_d = merge(sr2_q, (op_q == OP_WR_SR1) ? wb1_q : wb0_q, SR2_WMASK);
          if (op_q == OP_WR_SR3) sr3_d = merge(sr3_q, wb0_q, SR3_WMASK);
          if (!vwe_q) begin
            if (op_q == OP_WR_SR1) nv1_d = merge(nv1_q, wb0_q, SR1_WMASK);
            if (wr2) nv2_d = merge(nv2_q, (op_q == OP_WR_SR1) ? wb1_q : wb0_q, SR2_WMASK);
            if (op_q == OP_WR_SR3) nv3_d = merge(nv3_q, wb0_q, SR3_WMASK);
            opc_d = EMB_OP_CYC;
            sr1_d[SR1_BUSY] = 1'b1;
          end
        end
        vwe_d = 1'b0;
      end
    end else begin
      // pause follows its pin only while the clock is low
      if (!sclk) hold_d = hold_en & ~ln2_q[LK_PIN3] & ~cmd_q.quad;
      if (!hold_q && rise) begin
        case (ph_q)
          PH_CMD: begin
            sh_d = b;
            cnt_d = cnt_q + 1'b1;
            if (cnt_q == 5'(BYTE_BITS - 1'b1)) begin
              c = decode(b);
              op_d = b; cmd_d = c; cnt_d = '0; ph_d = PH_IGN;
              // reset period, busy and quad-off refuse the command
              if (srt_q == '0 && (!sr1_q[SR1_BUSY] || b == OP_RD_SR1) && !(c.quad && !qe)) begin
                arm_d = (b == OP_RST_EN);
                if (b != OP_VWREN && !is_wrsr(b)) vwe_d = 1'b0;
                if (c.has_addr) ph_d = PH_ADDR;
                else if (c.rd) ph_d = PH_OUT;
                else if (is_wrsr(b)) ph_d = PH_IN;
                case (b)
                  OP_WREN: sr1_d[SR1_WEL] = 1'b1;
                  OP_WRDI: sr1_d[SR1_WEL] = 1'b0;
                  OP_VWREN: vwe_d = 1'b1;
                  OP_RST: if (arm_q) begin
                    init = 1'b1;
                    srt_d = SW_RST_CYC;
                  end
                  default: ;
                endcase
              end
            end
          end
          PH_ADDR: begin
            w = lane_w(cmd_q.alanes);
            cnt_d = cnt_q + 5'(w);
            if (5'(cnt_q + 5'(w)) == ADDR_BITS) begin
              cnt_d = '0;
              if (cmd_q.dummy != '0) ph_d = PH_DUMMY;
              else if (cmd_q.rd) ph_d = PH_OUT;
              else begin
                ph_d = PH_IGN;
                if (sr1_q[SR1_WEL]) begin
                  opc_d = EMB_OP_CYC;
                  sr1_d[SR1_BUSY] = 1'b1;
                end
              end
            end
          end
          PH_DUMMY: begin
            cnt_d = cnt_q + 1'b1;
            if (5'(cnt_q + 1'b1) == 5'(cmd_q.dummy)) ph_d = PH_OUT;
          end
          PH_IN: begin
            sh_d = b;
            cnt_d = cnt_q + 1'b1;
            if (cnt_q == 5'(BYTE_BITS - 1'b1)) begin
              cnt_d = '0;
              if (nb_q == 2'h0) wb0_d = b;
              if (nb_q == 2'h1) wb1_d = b;
              if (nb_q != 2'h2) nb_d = nb_q + 1'b1;
            end
          end
          default: ;
        endcase
      end
      if (!hold_q && fall && ph_q == PH_OUT) begin
        w = lane_w(cmd_q.dlanes);
        if (oleft_q == '0) begin
          case (op_q)
            OP_RD_SR1: by = sr1_q;
            OP_RD_SR2: by = sr2_q;
            OP_RD_SR3: by = sr3_q;
            default: by = ERASED; // no array behind this end: reads as erased
          endcase
        end
        case (cmd_q.dlanes)
          LN_ONE: begin
            io_o_d = {2'h0, by[7], 1'b0}; drv_d = 4'h2;
          end
          LN_TWO: begin
            io_o_d = {2'h0, by[7:6]}; drv_d = 4'h3;
          end
          default: begin
            io_o_d = by[7:4]; drv_d = 4'hf;
          end
        endcase
        osh_d = 8'(by << w);
        oleft_d = ((oleft_q == '0) ? BYTE_BITS : oleft_q) - w;
      end
    end
    // software or pin reset: power-on state from the stored bits
    if (init) begin
      sr1_d = {nv1_q[7:2], 2'h0}; sr2_d = {1'b0, nv2_q[6:0]}; sr3_d = nv3_q;
      opc_d = '0; arm_d = 1'b0; vwe_d = 1'b0; hold_d = 1'b0; drv_d = '0;
      ph_d = PH_IGN;
    end
    oe_n_d = hold_d ? 4'hf : ~drv_d;
    rst_act_d = pin_low | (srt_d != '0);
  end

  // stored and volatile bits all power up cleared
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      ph_q <= PH_CMD; cmd_q <= '0; cnt_q <= '0; op_q <= '0; sh_q <= '0;
      wb0_q <= '0; wb1_q <= '0; osh_q <= '0; nb_q <= '0; oleft_q <= '0;
      sr1_q <= '0; sr2_q <= '0; sr3_q <= '0; nv1_q <= '0; nv2_q <= '0; nv3_q <= '0;
      io_o_q <= '0; drv_q <= '0; oe_n_q <= 4'hf; hold_q <= 1'b0; arm_q <= 1'b0; vwe_q <= 1'b0;
      opc_q <= '0; srt_q <= '0; rpc_q <= '0; rst_act_q <= 1'b0;
    end else begin
      ph_q <= ph_d; cmd_q <= cmd_d; cnt_q <= cnt_d; op_q <= op_d; sh_q <= sh_d;
      wb0_q <= wb0_d; wb1_q <= wb1_d; osh_q <= osh_d; nb_q <= nb_d; oleft_q <= oleft_d;
      sr1_q <= sr1_d; sr2_q <= sr2_d; sr3_q <= sr3_d; nv1_q <= nv1_d; nv2_q <= nv2_d; nv3_q <= nv3_d;
      io_o_q <= io_o_d; drv_q <= drv_d; oe_n_q <= oe_n_d; hold_q <= hold_d; arm_q <= arm_d; vwe_q <= vwe_d;
      opc_q <= opc_d; srt_q <= srt_d; rpc_q <= rpc_d; rst_act_q <= rst_act_d;
    end
  end

  assign spi.d_o = io_o_q;
  assign spi.d_oe_n = oe_n_q;
  assign status_one_protection = sr1_q;
  assign four_line_enable = sr2_q[SR2_QE];
  assign pin_function_select = sr3_q[SR3_PFS];
  assign reset_active = rst_act_q;
endmodule : fmh_dev

//--- rtl/fmh_host.sv
// controller end: apb registers driving one serial byte at a time
module fmh_host
  import fmh_pkg::*;
(
  input wire logic ref_clk,
  input wire logic resetn,
  fmh_spi_if.host spi,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [APB_AW-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr
);
  typedef enum logic [1:0] {H_IDLE, H_LOW, H_HIGH} fmh_hst_t;

  // host lane placement: single mode sends on line zero
  function automatic logic [3:0] put_bits(input logic [7:0] v, input fmh_lanes_t l);
    case (l)
      LN_ONE: put_bits = {3'h0, v[7]};
      LN_TWO: put_bits = {2'h0, v[7:6]};
      default: put_bits = v[7:4];
    endcase
  endfunction : put_bits

  fmh_hst_t st_q, st_d;
  logic [XF_W-1:0] xfer_q, xfer_d;
  logic [1:0] pins_q, pins_d;
  logic [7:0] div_q, div_d, tm_q, tm_d, sh_q, sh_d, rx_q, rx_d, samp;
  logic [3:0] left_q, left_d, o_q, o_d, oe_n_q, oe_n_d, in1_q, in2_q, w;
  logic [31:0] prdata_q, prdata_d;
  logic pready_q, pready_d, pslverr_q, pslverr_d, sclk_q, sclk_d, cs_n_q, cs_n_d;
  logic acc, hit, wr_go;
  fmh_lanes_t ln;

  ////////////////////////////////////////////////////////////////////////////////
  // data lines return from the device's domain
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      in1_q <= 4'hf;
      in2_q <= 4'hf;
    end else begin
      in1_q <= spi.io;
      in2_q <= in1_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // register slave (one wait state) and byte engine
  always_comb begin
    st_d = st_q; xfer_d = xfer_q; pins_d = pins_q; div_d = div_q; tm_d = tm_q;
    sh_d = sh_q; rx_d = rx_q; left_d = left_q; sclk_d = sclk_q; cs_n_d = cs_n_q;
    acc = psel & penable;
    wr_go = acc & pready_q & pwrite;
    pready_d = acc & ~pready_q;
    hit = (paddr == A_XFER) || (paddr == A_STAT) || (paddr == A_PINS) || (paddr == A_DIV);
    pslverr_d = acc & ~pready_q & ~hit;
    case (paddr)
      A_XFER: prdata_d = {20'h0, xfer_q};
      A_STAT: prdata_d = {16'h0, rx_q, 7'h0, st_q != H_IDLE};
      A_PINS: prdata_d = {30'h0, pins_q};
      A_DIV: prdata_d = {24'h0, div_q};
      default: prdata_d = '0;
    endcase
    if (!pready_d) prdata_d = '0;
    ln = fmh_lanes_t'(xfer_q[XF_LANE +: 2]);
    w = lane_w(ln);
    case (ln)
      LN_ONE: samp = {7'h0, in2_q[1]};
      LN_TWO: samp = {6'h0, in2_q[1:0]};
      default: samp = {4'h0, in2_q};
    endcase
    // a transfer write while busy is dropped
    if (wr_go && paddr == A_XFER && st_q == H_IDLE) begin
      xfer_d = pwdata[XF_W-1:0];
      sh_d = pwdata[7:0];
      left_d = BYTE_BITS;
      cs_n_d = 1'b0;
      tm_d = div_q;
      st_d = H_LOW;
    end
    if (wr_go && paddr == A_PINS) pins_d = pwdata[1:0];
    // too short a half period would outrun the device's input sampling
    if (wr_go && paddr == A_DIV) div_d = (pwdata[7:0] < DIV_MIN) ? DIV_MIN : pwdata[7:0];
    case (st_q)
      H_LOW: begin
        tm_d = tm_q - 1'b1;
        if (tm_q <= 8'h1) begin
          sclk_d = 1'b1;
          tm_d = div_q;
          st_d = H_HIGH;
        end
      end
      H_HIGH: begin
        tm_d = tm_q - 1'b1;
        if (tm_q <= 8'h1) begin
          // sample at the end of the high half: device output has settled
          rx_d = 8'(rx_q << w) | samp;
          sh_d = 8'(sh_q << w);
          left_d = left_q - w;
          sclk_d = 1'b0;
          tm_d = div_q;
          st_d = H_LOW;
          if (left_q == w) begin
            st_d = H_IDLE;
            cs_n_d = xfer_q[XF_END];
          end
        end
      end
      default: ;
    endcase
    // drive pattern; guard and pause/reset pins follow PINS outside quad
    ln = fmh_lanes_t'(xfer_d[XF_LANE +: 2]);
    o_d = put_bits(sh_d, ln);
    oe_n_d = 4'hf;
    if (ln == LN_ONE) oe_n_d[0] = 1'b0;
    else if (!xfer_d[XF_RD]) oe_n_d = (ln == LN_TWO) ? 4'hc : 4'h0;
    if (ln != LN_FOUR) begin
      o_d[3:2] = {pins_d[PN_PIN3], pins_d[PN_GUARD]};
      oe_n_d[3:2] = 2'h0;
    end
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      st_q <= H_IDLE; xfer_q <= '0; pins_q <= PINS_RST; div_q <= DIV_RST; tm_q <= '0;
      sh_q <= '0; rx_q <= '0; left_q <= '0; sclk_q <= 1'b0; cs_n_q <= 1'b1;
      o_q <= 4'hc; oe_n_q <= 4'h2; prdata_q <= '0; pready_q <= 1'b0; pslverr_q <= 1'b0;
    end else begin
      st_q <= st_d; xfer_q <= xfer_d; pins_q <= pins_d; div_q <= div_d; tm_q <= tm_d;
      sh_q <= sh_d; rx_q <= rx_d; left_q <= left_d; sclk_q <= sclk_d; cs_n_q <= cs_n_d;
      o_q <= o_d; oe_n_q <= oe_n_d; prdata_q <= prdata_d; pready_q <= pready_d; pslverr_q <= pslverr_d;
    end
  end

  assign spi.sclk = sclk_q;
  assign spi.cs_n = cs_n_q;
  assign spi.h_o = o_q;
  assign spi.h_oe_n = oe_n_q;
  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
endmodule : fmh_host

//--- dv/fmh_chk.sv
// link and status checks beside the interface joining the two ends
module fmh_chk (
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic [3:0] h_oe_n,
  input wire logic [3:0] d_oe_n,
  input wire logic [7:0] status_one_protection,
  input wire logic four_line_enable,
  input wire logic reset_active
);
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!resetn);
  ////////////////////////////////////////////////////////////////////////////////
  // sync delay of the device end needs a few cycles of slack after deselect
  no_fight_a: assert property (&(d_oe_n | h_oe_n)) else $error("both ends drive one lane");
  sclk_idle_a: assert property (cs_n |-> !sclk) else $error("clock not low while deselected");
  quad_lanes_a: assert property (!four_line_enable |-> &d_oe_n[3:2]) else $error("upper lanes driven");
  busy_permit_a: assert property (status_one_protection[0] |-> status_one_protection[1])
    else $error("busy without permit");
  busy_len_a: assert property ($rose(status_one_protection[0]) |-> ##49 status_one_protection[0]
    ##1 !status_one_protection[0]) else $error("busy length wrong");
  permit_clr_a: assert property ($fell(status_one_protection[0]) |-> !status_one_protection[1])
    else $error("permit kept after operation");
  rst_end_a: assert property ($fell(reset_active) |-> status_one_protection[1:0] == 2'h0)
    else $error("flags left after reset");
  rst_quiet_a: assert property (reset_active && $past(reset_active) |-> &d_oe_n)
    else $error("device drives during reset");
  desel_float_a: assert property (cs_n [*6] |-> &d_oe_n) else $error("device drives deselected");
  busy_c: cover property ($rose(status_one_protection[0]));
  reset_c: cover property ($rose(reset_active));
  drive_c: cover property (!d_oe_n[1]);
  dual_c: cover property (d_oe_n[1:0] == 2'h0);
endmodule : fmh_chk

//--- dv/tb_flash_multi_io_hold_reset_status.sv
// self-checking bench: the controller end drives the flash end over the link
module tb_flash_multi_io_hold_reset_status import fmh_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;
  logic ref_clk = 1'b0, resetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, note = 1'b0;
  logic [APB_AW-1:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic pready, pslverr, er, four_line_enable, pin_function_select, reset_active;
  logic [7:0] status_one_protection, d, v;
  logic [31:0] exp_q[$];
  int num_errors = 0, samples_checked = 0;
  fmh_spi_if s();
  fmh_dev i_fmh_dev (.ref_clk(ref_clk), .resetn(resetn), .spi(s), .status_one_protection(status_one_protection),
    .four_line_enable(four_line_enable), .pin_function_select(pin_function_select), .reset_active(reset_active));
  fmh_host i_fmh_host (.ref_clk(ref_clk), .resetn(resetn), .spi(s), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
  fmh_chk i_fmh_chk (.ref_clk(ref_clk), .resetn(resetn), .sclk(s.sclk), .cs_n(s.cs_n), .h_oe_n(s.h_oe_n),
    .d_oe_n(s.d_oe_n), .status_one_protection(status_one_protection), .four_line_enable(four_line_enable),
    .reset_active(reset_active));
  initial forever #20 ref_clk = ~ref_clk;
  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string n, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("MISMATCH %s exp %h seen %h", n, exp, seen);
    end
  endtask : chk
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : end_of_test
  // one apb transfer; an idle cycle after it keeps each strobe to one write per step
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] wd);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge ref_clk);
    penable <= 1'b1;
    do begin
      @(posedge ref_clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1) begin
      num_errors++;
      end_of_test();
    end
    @(posedge ref_clk);
  endtask : apb
  // read whose expected data is noted for the watcher
  task automatic rdx(input logic [11:0] a, input logic [31:0] e);
    exp_q.push_back(e);
    note = 1'b1;
    apb(1'b0, a, 32'h0);
    note = 1'b0;
  endtask : rdx
  // one link byte: {end, read, lanes, byte}, then poll until the controller is idle
  task automatic send(input logic [11:0] x);
    int n;
    n = 0;
    apb(1'b1, A_XFER, {20'h0, x});
    do begin
      apb(1'b0, A_STAT, 32'h0);
      n++;
    end while (rd[0] !== 1'b0 && n < 100);
    if (rd[0] !== 1'b0) begin
      num_errors++;
      end_of_test();
    end
  endtask : send
  // watcher: compares read data with the oldest note
  always @(posedge ref_clk) if (note && psel && penable && pready === 1'b1) chk("prdata", prdata, exp_q.pop_front());
  initial begin
    void'($urandom(87));
    d = 8'($urandom) & 8'h7c;
    v = ~d & 8'h7c;
    repeat (8) @(posedge ref_clk);
    resetn <= 1'b1;
    repeat (3) @(posedge ref_clk);
    rdx(A_PINS, {30'h0, PINS_RST});
    rdx(A_DIV, {24'h0, DIV_RST});
    rdx(12'h010, 32'h0);
    chk("pslverr", {31'h0, er}, 32'h1);
    $display("test registers done");
    send(12'h806);
    send(12'h005);
    send(12'hc00);
    rdx(A_STAT, 32'h0200);
    $display("test permit done");
    send(12'h001);
    send({4'h8, d});
    repeat (8) @(posedge ref_clk);
    chk("busy", {30'h0, status_one_protection[1:0]}, 32'h3);
    repeat (60) @(posedge ref_clk);
    chk("stored", {24'h0, status_one_protection}, {24'h0, d});
    send(12'h850);
    send(12'h001);
    send({4'h8, v});
    repeat (8) @(posedge ref_clk);
    chk("volatile", {24'h0, status_one_protection}, {24'h0, v});
    $display("test status writes done");
    send(12'h866);
    send(12'h899);
    repeat (8) @(posedge ref_clk);
    chk("swreset", {31'h0, reset_active}, 32'h1);
    repeat (260) @(posedge ref_clk);
    chk("reload", {24'h0, status_one_protection}, {24'h0, d});
    // pause with the clock low mid-read: the paused byte floats to all ones
    send(12'h005);
    apb(1'b1, A_PINS, 32'h1);
    send(12'h400);
    rdx(A_STAT, 32'hff00);
    apb(1'b1, A_PINS, 32'h3);
    send(12'hc00);
    rdx(A_STAT, {16'h0, d, 8'h0});
    $display("test pause done");
    // dual output read: dummy clocks sent with the lanes released
    send(12'h03b);
    repeat (3) send(12'h000);
    repeat (2) send(12'h500);
    send(12'hd00);
    rdx(A_STAT, 32'hff00);
    $display("test dual read done");
    send(12'h850);
    send(12'h011);
    send(12'h880);
    repeat (8) @(posedge ref_clk);
    chk("pinsel", {31'h0, pin_function_select}, 32'h1);
    apb(1'b1, A_PINS, 32'h1);
    repeat (16) @(posedge ref_clk);
    chk("pinreset", {31'h0, reset_active}, 32'h1);
    // a full-width pulse reloads the volatile select from its stored copy
    repeat (24) @(posedge ref_clk);
    chk("pinreload", {31'h0, pin_function_select}, 32'h0);
    apb(1'b1, A_PINS, 32'h3);
    repeat (8) @(posedge ref_clk);
    chk("pinsel0", {31'h0, pin_function_select}, 32'h0);
    $display("test resets done");
    end_of_test();
  end
endmodule : tb_flash_multi_io_hold_reset_status
